/* File: hw/bsacfg_consts.svh */
// Offsets, field positions, reset values and codes of the register slice.
`ifndef BSACFG_CONSTS_SVH
`define BSACFG_CONSTS_SVH
`define BSACFG_ADDR_FAULT   8'h12
`define BSACFG_ADDR_ACTION  8'h13
`define BSACFG_ADDR_IFCFG   8'h14
`define BSACFG_RST_FAULT    14'h0000
`define BSACFG_RST_IFCFG    16'hc101
`define BSACFG_POR_BIT      0
`define BSACFG_CFG_MSB      15
`define BSACFG_CFG_LSB      14
`define BSACFG_UPIDLE_BIT   13
`define BSACFG_HOST_BIT     8
`define BSACFG_RO_MASK      16'h0100
`define BSACFG_DUAL_UART    2'h3
`define BSACFG_SCAN_BAL_LO  3'h4
`define BSACFG_CELL_LAST    4'hd
`endif

/* File: hw/bsacfg_pkg.sv */
// Types shared by the balance alert and interface configuration slice.
package bsacfg_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_host_path;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bsacfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] fail;
    logic [2:0]  scan_configuration;
  } bsacfg_acq_t;

  typedef enum logic [1:0] {
    BSACFG_RUN   = 2'b00,
    BSACFG_RESET = 2'b01
  } bsacfg_state_t;
endpackage : bsacfg_pkg

/* File: hw/bsacfg_regs.sv */
// Balance switch fault, software action and interface configuration registers.
`include "bsacfg_consts.svh"

// What this block does
// - Set fault bit when balance scan fails
// - Mask fault bits above top cell
// - Fault bits read-only, clear on next balance scan
// - Writing one requests software reset
// - Software reset bit always reads zero
// - Interface field resets to dual UART
// - Software reset keeps interface field
// - Dual UART: only host path writes
// - Upper transmitter idle select set turns idle output enable off
module bsacfg_regs
  import bsacfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Register command from the serial link decoder
  input  bsacfg_req_t      req,
  output logic [15:0]      rdata_q,
  output logic             rvalid_q,
  // Acquisition results and pack configuration
  input  bsacfg_acq_t      acq,
  input  wire logic [3:0]  top_cell_position_one,
  // Device control
  output logic             software_reset_request,
  output logic [1:0]       interface_config_field,
  output logic             upper_tx_idle_select,
  output logic             upper_transmitter_idle_oe,
  output logic             host_path_indicator
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int unsigned CH_COUNT  = `BSACFG_CELL_LAST + 1;
  localparam int unsigned LOW_MSB   = `BSACFG_CFG_LSB - 1;
  localparam logic [15:0] IFCFG_RST = `BSACFG_RST_IFCFG;
  localparam logic [15:0] RO_MASK   = `BSACFG_RO_MASK;
  localparam logic [15:0] RD_IDLE   = 16'h0000;

  // ----------------------------------------------------------------------
  // Command decoding and write qualification
  // ----------------------------------------------------------------------
  logic [13:0]   fault_q;
  logic [1:0]    cfg_field_q;
  logic [13:0]   cfg_low_q;
  logic [15:0]   ifcfg_word;
  bsacfg_state_t state_q;
  logic          soft_rst;
  logic          rd_req;
  logic          path_ok;
  logic          wr_ok;
  logic          wr_action;
  logic          wr_ifcfg;
  logic          por_take;
  logic          acq_take;
  logic [13:0]   cell_mask;
  logic [15:0]   rd_word;

  assign ifcfg_word = {cfg_field_q, cfg_low_q};
  assign soft_rst   = (state_q == BSACFG_RESET);
  assign rd_req     = req.valid && !req.write;
  assign path_ok    = (cfg_field_q != `BSACFG_DUAL_UART) ||
                      req.from_host_path;
  assign wr_ok      = req.valid && req.write && path_ok;
  assign wr_action  = wr_ok && (req.addr == `BSACFG_ADDR_ACTION);
  assign wr_ifcfg   = wr_ok && (req.addr == `BSACFG_ADDR_IFCFG);
  assign por_take   = wr_action && req.wdata[`BSACFG_POR_BIT];
  assign acq_take   = acq.valid &&
                      (acq.scan_configuration >= `BSACFG_SCAN_BAL_LO);

  genvar gi;
  generate
    for (gi = 0; gi < CH_COUNT; gi++)
    begin : g_mask
      assign cell_mask[gi] = (4'(gi) <= top_cell_position_one);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Software reset sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= BSACFG_RUN;
    end
    else if (soft_rst)
    begin
      state_q <= BSACFG_RUN;
    end
    else if (por_take)
    begin
      state_q <= BSACFG_RESET;
    end
  end

  assign software_reset_request = soft_rst;

  // ----------------------------------------------------------------------
  // Balance switch fault bits
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_q <= `BSACFG_RST_FAULT;
    end
    else if (soft_rst)
    begin
      fault_q <= `BSACFG_RST_FAULT;
    end
    else if (acq_take)
    begin
      fault_q <= acq.fail & cell_mask;
    end
  end

  // ----------------------------------------------------------------------
  // Interface configuration field
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_field_q <= IFCFG_RST[`BSACFG_CFG_MSB:`BSACFG_CFG_LSB];
    end
    else if (soft_rst)
    begin
      cfg_field_q <= cfg_field_q;
    end
    else if (wr_ifcfg)
    begin
      cfg_field_q <= req.wdata[`BSACFG_CFG_MSB:`BSACFG_CFG_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Remaining configuration bits, host path indicator kept read-only
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_low_q <= IFCFG_RST[LOW_MSB:0];
    end
    else if (soft_rst)
    begin
      cfg_low_q <= IFCFG_RST[LOW_MSB:0];
    end
    else if (wr_ifcfg)
    begin
      cfg_low_q <= (req.wdata[LOW_MSB:0] & ~RO_MASK[LOW_MSB:0]) |
                   (cfg_low_q & RO_MASK[LOW_MSB:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  assign interface_config_field    = cfg_field_q;
  assign upper_tx_idle_select      = ifcfg_word[`BSACFG_UPIDLE_BIT];
  assign upper_transmitter_idle_oe = ~ifcfg_word[`BSACFG_UPIDLE_BIT];
  assign host_path_indicator       = ifcfg_word[`BSACFG_HOST_BIT];

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_word = RD_IDLE;
    unique case (req.addr)
      `BSACFG_ADDR_FAULT:
      begin
        rd_word = {2'h0, fault_q & cell_mask};
      end
      `BSACFG_ADDR_ACTION:
      begin
        rd_word = RD_IDLE;
      end
      `BSACFG_ADDR_IFCFG:
      begin
        rd_word = ifcfg_word;
      end
      default:
      begin
        rd_word = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd_req;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= RD_IDLE;
    end
    else if (rd_req)
    begin
      rdata_q <= rd_word;
    end
  end

endmodule : bsacfg_regs

/* File: sim/bsacfg_host.sv */
// Host model issuing register commands.
module bsacfg_host
  import bsacfg_pkg::*;
(
  input wire logic        clk_sys, rvalid_q,
  input wire logic [15:0] rdata_q,
  output bsacfg_req_t     req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Software reset is issued once only, in the final reset test.
  task xfer(input logic w, h, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] q);
    @(posedge clk_sys);
    #1 req = {1'b1, w, h, a, d};
    @(posedge clk_sys);
    #1 req.valid = 1'b0;
    q = rvalid_q ? rdata_q : 16'hxxxx;
  endtask : xfer
endmodule : bsacfg_host

/* File: sim/bsacfg_props.sv */
// Port assertions for the register slice.
module bsacfg_props
  import bsacfg_pkg::*;
(
  input wire logic        clk_sys, rstn, rvalid_q, software_reset_request,
  input wire logic        upper_tx_idle_select, upper_transmitter_idle_oe,
  input wire logic [15:0] rdata_q,
  input wire logic [1:0]  interface_config_field,
  input wire logic [3:0]  top_cell_position_one,
  input bsacfg_req_t      req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic por_wr, cfg_wr;
  assign por_wr = req.valid & req.write & (req.addr == 8'h13) & req.wdata[0]
    & (interface_config_field != 2'h3 | req.from_host_path)
    & !software_reset_request;
  assign cfg_wr = req.valid & req.write & (req.addr == 8'h14);
  sequence s_por; software_reset_request ##1 !software_reset_request;
  endsequence
  a_por_pulse: assert property (por_wr |=> s_por)
    else $error("reset pulse missing");
  a_por_cause: assert property (software_reset_request |-> $past(por_wr))
    else $error("stray reset pulse");
  a_zero_read: assert property (rvalid_q && $past(req.addr) == 8'h13
    |-> rdata_q == 16'h0) else $error("reset bit read back");
  a_cfg_kept: assert property (software_reset_request
    |=> $stable(interface_config_field)) else $error("field lost");
  a_idle_drive: assert property (upper_transmitter_idle_oe
    != upper_tx_idle_select) else $error("idle enable wrong");
  a_path_block: assert property (cfg_wr && !req.from_host_path
    && interface_config_field == 2'h3 && !software_reset_request
    |=> $stable(upper_tx_idle_select)) else $error("path write taken");
  a_host_write: assert property (cfg_wr && req.from_host_path
    && !software_reset_request |=> upper_tx_idle_select
    == $past(req.wdata[13])) else $error("host write lost");
  a_fault_mask: assert property (rvalid_q && $past(req.addr) == 8'h12
    |-> (rdata_q >> ($past(top_cell_position_one) + 1)) == 16'h0)
    else $error("masked fault seen");
endmodule : bsacfg_props
bind bsacfg_regs bsacfg_props chk_u (
  .clk_sys                   (clk_sys),
  .rstn                      (rstn),
  .rvalid_q                  (rvalid_q),
  .software_reset_request    (software_reset_request),
  .upper_tx_idle_select      (upper_tx_idle_select),
  .upper_transmitter_idle_oe (upper_transmitter_idle_oe),
  .rdata_q                   (rdata_q),
  .interface_config_field    (interface_config_field),
  .top_cell_position_one     (top_cell_position_one),
  .req                       (req)
);

/* File: sim/testbench.sv */
// Self-checking bench for the register slice.
module testbench;
  import bsacfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, rstn = 0, rvalid_q, srr, oe, ui, hp;
  logic [15:0] rdata_q, q;
  logic [1:0]  icf;
  logic [3:0]  top = 4'h3;
  bsacfg_req_t req;
  bsacfg_acq_t acq = '0;
  int          err_total, n_compared, cyc;
  always #10 clk_sys = ~clk_sys;
  bsacfg_regs dut_u (.clk_sys, .rstn, .req, .rdata_q, .rvalid_q, .acq,
    .top_cell_position_one(top), .software_reset_request(srr),
    .interface_config_field(icf), .upper_tx_idle_select(ui),
    .upper_transmitter_idle_oe(oe), .host_path_indicator(hp));
  bsacfg_host host_u (.clk_sys, .rvalid_q, .rdata_q, .req);
  task chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [15:0] e);
    host_u.xfer(0, 1, a, 0, q);
    chk("rdata_q", e, q);
  endtask : rd
  task scan(input logic [13:0] f, input logic [2:0] s);
    @(posedge clk_sys);
    #1 acq = {1'b1, f, s};
    @(posedge clk_sys);
    #1 acq.valid = 0;
  endtask : scan
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys)
    if (++cyc == 3000)
    begin
      err_total++;
      end_of_test();
    end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1 rstn = 1;
    rd(8'h14, 16'hc101);
    chk("host_path_indicator", 1, hp);
    host_u.xfer(1, 0, 8'h14, 16'h2000, q);
    rd(8'h14, 16'hc101);
    host_u.xfer(1, 1, 8'h14, 16'he000, q);
    rd(8'h14, 16'he100);
    chk("upper_transmitter_idle_oe", 0, oe);
    chk("upper_tx_idle_select", 1, ui);
    $display("config test done");
    scan(14'h3fff, 3'h3);
    rd(8'h12, 16'h0);
    scan(14'h3fff, 3'h4);
    rd(8'h12, 16'h000f);
    top = 4'hd;
    for (int s = 4; s < 8; s++)
    begin
      scan(14'h1 << (s + 6), 3'(s));
      rd(8'h12, 16'h1 << (s + 6));
    end
    host_u.xfer(1, 1, 8'h12, 16'hffff, q);
    rd(8'h12, 16'h2000);
    $display("fault test done");
    host_u.xfer(1, 1, 8'h14, 16'h4000, q);
    host_u.xfer(1, 1, 8'h13, 16'h0001, q);
    chk("software_reset_request", 1, srr);
    rd(8'h13, 16'h0);
    rd(8'h14, 16'h4101);
    chk("interface_config_field", 1, icf);
    rd(8'h12, 16'h0);
    $display("reset test done");
    end_of_test();
  end
endmodule : testbench
